// File: pkg/cim_consts.svh
`ifndef CIM_CONSTS_SVH
`define CIM_CONSTS_SVH

// ****************************************************
// Register map
// ****************************************************
`define CIM_ADDR_CFG 8'h00
`define CIM_ADDR_SYNC 8'h04
`define CIM_ADDR_FREQ 8'h08
`define CIM_ADDR_PHASE 8'h0C
`define CIM_ADDR_STATUS 8'h10
`define CIM_CFG_FULL 0
`define CIM_CFG_GAIN 1
`define CIM_CFG_CMIX_LO 4
`define CIM_SYNC_SW 8
`define CIM_CFG_RESET 8'h00
`define CIM_SYNC_RESET 4'h0
`define CIM_FREQ_RESET 32'h0000_0000
`define CIM_PHASE_RESET 16'h0000
`define CIM_RESP_OKAY 2'h0
`define CIM_RESP_SLVERR 2'h2

// ****************************************************
// Arithmetic
// ****************************************************
`define CIM_SINE_TAB {16'h7FFF, 16'h7F61, 16'h7D89, 16'h7A7C, 16'h7641, 16'h70E2, 16'h6A6D, 16'h62F1, \
    16'h5A82, 16'h5133, 16'h471C, 16'h3C56, 16'h30FB, 16'h2528, 16'h18F9, 16'h0C8C, 16'h0000}
`define CIM_TAB_HALF 5'h10
`define CIM_COS_SHIFT 6'h10
`define CIM_ACC_TOP 26
`define CIM_OFS_TOP 10
`define CIM_RND_G1 34'sh0000_4000
`define CIM_RND_G0 34'sh0000_8000
`define CIM_SHIFT_G1 15
`define CIM_SHIFT_G0 16
`define CIM_SAMPLE_MAX 16'sh7FFF
`define CIM_SAMPLE_MIN 16'sh8000
`define CIM_HALF_PEAK 16'sd23171

`endif

// File: pkg/cim_pkg.sv
`default_nettype none
package cim_pkg;
    typedef logic signed [15:0] cim_sample_t;
    typedef logic [1:0] cim_quarter_t;
    typedef enum logic [3:0] {
        CIM_NONE = 4'b0000,
        CIM_NEG_FS4 = 4'b0001,
        CIM_FS2 = 4'b0010,
        CIM_POS_FS4 = 4'b0100,
        CIM_POS_FS8 = 4'b1000,
        CIM_NEG_3FS8 = 4'b1010,
        CIM_POS_3FS8 = 4'b1100,
        CIM_NEG_FS8 = 4'b1110
    } cim_cmix_t;
endpackage
`default_nettype wire

// File: logic/cim_mixer.sv
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "cim_consts.svh"
module cim_mixer
    import cim_pkg::*;
(
    input wire logic CLOCK, // Sample clock
    input wire logic RST, // Synchronous reset, high
    input wire logic CE, // Clock enable, freezes all
    input wire logic [2:0] SYNC_IN, // External sync pulses
    input wire cim_sample_t A_I, // Path A in-phase in
    input wire cim_sample_t A_Q, // Path A quadrature in
    input wire cim_sample_t B_I, // Path B in-phase in
    input wire cim_sample_t B_Q, // Path B quadrature in
    output cim_sample_t OUT_A_I, // Path A in-phase out
    output cim_sample_t OUT_A_Q, // Path A quadrature out
    output cim_sample_t OUT_B_I, // Path B in-phase out
    output cim_sample_t OUT_B_Q, // Path B quadrature out
    input wire logic [7:0] S_AXI_AWADDR, // Write address
    input wire logic S_AXI_AWVALID, // Write address valid
    output logic S_AXI_AWREADY, // Write address ready
    input wire logic [31:0] S_AXI_WDATA, // Write data
    input wire logic [3:0] S_AXI_WSTRB, // Write strobes
    input wire logic S_AXI_WVALID, // Write data valid
    output logic S_AXI_WREADY, // Write data ready
    output logic [1:0] S_AXI_BRESP, // Write response
    output logic S_AXI_BVALID, // Write response valid
    input wire logic S_AXI_BREADY, // Write response ready
    input wire logic [7:0] S_AXI_ARADDR, // Read address
    input wire logic S_AXI_ARVALID, // Read address valid
    output logic S_AXI_ARREADY, // Read address ready
    output logic [31:0] S_AXI_RDATA, // Read data
    output logic [1:0] S_AXI_RRESP, // Read response
    output logic S_AXI_RVALID, // Read data valid
    input wire logic S_AXI_RREADY // Read response ready
);
    localparam int PATHS = 2;
    localparam logic [271:0] SINE_TAB = `CIM_SINE_TAB;

    // ****************************************************
    // Arithmetic helpers
    // ****************************************************
    // Quarter-wave table folded into a full turn of 64 steps
    function automatic cim_sample_t sine_of(input logic [5:0] p);
        logic [4:0] idx;
        cim_sample_t mag;
        idx = p[4] ? (`CIM_TAB_HALF - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
        mag = SINE_TAB[{idx, 4'h0} +: 16];
        return p[5] ? -mag : mag;
    endfunction

    function automatic cim_sample_t neg_sat(input cim_sample_t x);
        return (x == `CIM_SAMPLE_MIN) ? `CIM_SAMPLE_MAX : -x;
    endfunction

    // Round half up, then clip; wrapping would flip the sign of a peak
    function automatic cim_sample_t rnd_sat(input logic signed [32:0] s, input logic g);
        logic signed [33:0] r;
        r = g ? ((34'(s) + `CIM_RND_G1) >>> `CIM_SHIFT_G1) : ((34'(s) + `CIM_RND_G0) >>> `CIM_SHIFT_G0);
        if (r > 34'(`CIM_SAMPLE_MAX))
            return `CIM_SAMPLE_MAX;
        else if (r < 34'(`CIM_SAMPLE_MIN))
            return `CIM_SAMPLE_MIN;
        else
            return r[15:0];
    endfunction

    // Multiply by j^k using only negation and swapping
    function automatic logic [31:0] rotate_q(input cim_sample_t i, input cim_sample_t q, input cim_quarter_t k);
        unique case (k)
            2'h0: return {i, q};
            2'h1: return {neg_sat(q), i};
            2'h2: return {neg_sat(i), neg_sat(q)};
            2'h3: return {q, neg_sat(i)};
        endcase
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] m;
        m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
        return (old & ~m) | (d & m);
    endfunction

    // ****************************************************
    // Register bus
    // ****************************************************
    logic [7:0] cfg;
    logic [3:0] sync_sel;
    logic [31:0] freq_word;
    logic [15:0] phase_ofs;
    logic [31:0] acc;
    logic [2:0] smp_cnt;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;

    wire logic do_write = CE && aw_held && w_held && !bvalid;
    wire logic do_read = CE && S_AXI_ARVALID && !rvalid;
    wire logic wr_cfg = aw_addr == `CIM_ADDR_CFG;
    wire logic wr_sync = aw_addr == `CIM_ADDR_SYNC;
    wire logic wr_freq = aw_addr == `CIM_ADDR_FREQ;
    wire logic wr_phase = aw_addr == `CIM_ADDR_PHASE;
    wire logic wr_hit = wr_cfg || wr_sync || wr_freq || wr_phase;
    wire logic [31:0] cfg_word = {24'h0, cfg};
    wire logic [31:0] sync_word = {28'h0, sync_sel};
    wire logic [31:0] phase_word = {16'h0, phase_ofs};
    wire logic [31:0] cfg_new = merge_strb(cfg_word, w_data, w_strb);
    wire logic [31:0] sync_new = merge_strb(sync_word, w_data, w_strb);
    wire logic [31:0] freq_new = merge_strb(freq_word, w_data, w_strb);
    wire logic [31:0] phase_new = merge_strb(phase_word, w_data, w_strb);
    wire logic rd_cfg = S_AXI_ARADDR == `CIM_ADDR_CFG;
    wire logic rd_sync = S_AXI_ARADDR == `CIM_ADDR_SYNC;
    wire logic rd_freq = S_AXI_ARADDR == `CIM_ADDR_FREQ;
    wire logic rd_phase = S_AXI_ARADDR == `CIM_ADDR_PHASE;
    wire logic rd_status = S_AXI_ARADDR == `CIM_ADDR_STATUS;
    wire logic rd_hit = rd_cfg || rd_sync || rd_freq || rd_phase || rd_status;
    wire logic [31:0] next_rdata = rd_cfg ? cfg_word : rd_sync ? sync_word : rd_freq ? freq_word :
                                   rd_phase ? phase_word : rd_status ? acc : 32'h0000_0000;

    assign S_AXI_AWREADY = CE && !aw_held;
    assign S_AXI_WREADY = CE && !w_held;
    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP = bresp;
    assign S_AXI_ARREADY = CE && !rvalid;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RRESP = rresp;
    assign S_AXI_RDATA = rdata;

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `CIM_RESP_OKAY;
        end
        else if (CE)
        begin
            if (S_AXI_AWVALID && !aw_held)
            begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && !w_held)
            begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? `CIM_RESP_OKAY : `CIM_RESP_SLVERR;
            end
            else if (bvalid && S_AXI_BREADY)
                bvalid <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            cfg <= `CIM_CFG_RESET;
            sync_sel <= `CIM_SYNC_RESET;
            freq_word <= `CIM_FREQ_RESET;
            phase_ofs <= `CIM_PHASE_RESET;
        end
        else if (do_write)
        begin
            if (wr_cfg)
                cfg <= cfg_new[7:0];
            if (wr_sync)
                sync_sel <= sync_new[3:0];
            if (wr_freq)
                freq_word <= freq_new;
            if (wr_phase)
                phase_ofs <= phase_new[15:0];
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            rvalid <= 1'b0;
            rresp <= `CIM_RESP_OKAY;
            rdata <= 32'h0000_0000;
        end
        else if (CE)
        begin
            if (do_read)
            begin
                rvalid <= 1'b1;
                rresp <= rd_hit ? `CIM_RESP_OKAY : `CIM_RESP_SLVERR;
                rdata <= next_rdata;
            end
            else if (rvalid && S_AXI_RREADY)
                rvalid <= 1'b0;
        end
    end

    // ****************************************************
    // Oscillator and sample counter
    // ****************************************************
    wire logic full_en = cfg[`CIM_CFG_FULL];
    wire logic gain_sel = cfg[`CIM_CFG_GAIN];
    wire logic [3:0] cmix = cfg[`CIM_CFG_CMIX_LO +: 4];
    wire logic sw_sync = do_write && wr_sync && w_strb[1] && w_data[`CIM_SYNC_SW];
    wire logic sync_now = |(sync_sel & {SYNC_IN, sw_sync});
    // Wrapping add gives f = step * fclk / 2^32
    wire logic [31:0] next_acc = sync_now ? 32'h0000_0000 : acc + freq_word;
    wire logic [2:0] next_cnt = sync_now ? 3'h0 : smp_cnt + 3'h1;

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            acc <= 32'h0000_0000;
            smp_cnt <= 3'h0;
        end
        else if (CE)
        begin
            acc <= next_acc;
            smp_cnt <= next_cnt;
        end
    end

    // ****************************************************
    // Mixer paths
    // ****************************************************
    // Six phase bits keep the table tiny; spurs sit near -36 dBc
    wire logic [5:0] nco_angle = acc[31:`CIM_ACC_TOP] + phase_ofs[15:`CIM_OFS_TOP];
    wire logic [5:0] fs8_angle = {smp_cnt, 3'h0};
    wire logic [5:0] angle = full_en ? nco_angle : fs8_angle;
    wire cim_sample_t cos_t = sine_of(angle + `CIM_COS_SHIFT);
    wire cim_sample_t sin_t = sine_of(angle);
    wire logic use_mult = full_en || cmix[3];
    // Quarter turns summed from enabled sub-mixers
    wire cim_quarter_t turn_p = cmix[2] ? smp_cnt[1:0] : 2'h0;
    wire cim_quarter_t turn_h = cmix[1] ? {smp_cnt[0], 1'b0} : 2'h0;
    wire cim_quarter_t turn_n = cmix[0] ? smp_cnt[1:0] : 2'h0;
    wire cim_quarter_t turns = full_en ? 2'h0 : turn_p + turn_h - turn_n;
    wire cim_sample_t in_i [PATHS];
    wire cim_sample_t in_q [PATHS];
    logic [31:0] next_out [PATHS];
    cim_sample_t out_i [PATHS];
    cim_sample_t out_q [PATHS];

    assign in_i[0] = A_I;
    assign in_q[0] = A_Q;
    assign in_i[1] = B_I;
    assign in_q[1] = B_Q;

    for (genvar g = 0; g < PATHS; g++)
    begin : g_path
        wire logic signed [31:0] p_ic = in_i[g] * cos_t;
        wire logic signed [31:0] p_qs = in_q[g] * sin_t;
        wire logic signed [31:0] p_is = in_i[g] * sin_t;
        wire logic signed [31:0] p_qc = in_q[g] * cos_t;
        wire logic signed [32:0] sum_i = 33'(p_ic) - 33'(p_qs);
        wire logic signed [32:0] sum_q = 33'(p_is) + 33'(p_qc);
        wire cim_sample_t m_i = use_mult ? rnd_sat(sum_i, gain_sel) : in_i[g];
        wire cim_sample_t m_q = use_mult ? rnd_sat(sum_q, gain_sel) : in_q[g];
        assign next_out[g] = rotate_q(m_i, m_q, turns);
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            for (int k = 0; k < PATHS; k++)
            begin
                out_i[k] <= 16'sh0000;
                out_q[k] <= 16'sh0000;
            end
        end
        else if (CE)
        begin
            for (int k = 0; k < PATHS; k++)
            begin
                out_i[k] <= next_out[k][31:16];
                out_q[k] <= next_out[k][15:0];
            end
        end
    end

    assign OUT_A_I = out_i[0];
    assign OUT_A_Q = out_q[0];
    assign OUT_B_I = out_i[1];
    assign OUT_B_Q = out_q[1];

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    wire logic coarse_only = !full_en && !cmix[3];

    acc_step_a: assert property (CE && !sync_now |=> acc == $past(acc) + $past(freq_word))
        else $error("accumulator did not advance by step word");
    sync_clear_a: assert property (CE && sync_now |=> acc == 32'h0 && smp_cnt == 3'h0)
        else $error("sync did not clear accumulator and counter");
    sync_pin_a: assert property (CE && |(sync_sel[3:1] & SYNC_IN) |=> acc == 32'h0)
        else $error("selected sync pin ignored");
    nomix_pass_a: assert property (CE && coarse_only && cmix == 4'h0 |=>
        OUT_A_I == $past(A_I) && OUT_A_Q == $past(A_Q) && OUT_B_I == $past(B_I))
        else $error("bypass mode altered samples");
    half_neg_a: assert property (CE && coarse_only && cmix == 4'h2 && smp_cnt[0] && A_I != `CIM_SAMPLE_MIN |=>
        OUT_A_I == -$past(A_I) && OUT_B_Q == neg_sat($past(B_Q)))
        else $error("fs/2 odd sample not negated");
    quarter_pos_a: assert property (CE && coarse_only && cmix == 4'h4 && smp_cnt[1:0] == 2'h1 |=>
        OUT_A_I == neg_sat($past(A_Q)) && OUT_A_Q == $past(A_I))
        else $error("+fs/4 second sample wrong");
    quarter_neg_a: assert property (CE && coarse_only && cmix == 4'h1 && smp_cnt[1:0] == 2'h3 |=>
        OUT_A_I == neg_sat($past(A_Q)) && OUT_A_Q == $past(A_I))
        else $error("-fs/4 fourth sample wrong");
    gain_half_a: assert property (CE && use_mult && !gain_sel |=>
        OUT_A_I <= `CIM_HALF_PEAK && OUT_A_I >= -`CIM_HALF_PEAK)
        else $error("gain zero output exceeds half-scale peak");
    clip_top_a: assert property (CE && !full_en && cmix == 4'h8 && gain_sel && smp_cnt == 3'h1 &&
        A_I == `CIM_SAMPLE_MAX && A_Q == `CIM_SAMPLE_MAX |=> OUT_A_Q == `CIM_SAMPLE_MAX)
        else $error("overflow wrapped instead of clipping");
    bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped early");
    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && S_AXI_RDATA == $past(S_AXI_RDATA))
        else $error("read data dropped or changed early");
    cfg_write_a: assert property (do_write && wr_cfg && w_strb[0] |=> cfg == $past(w_data[7:0]))
        else $error("configuration write lost");

    // ****************************************************
    // Sequence, freeze, mixing and clipping checks
    // ****************************************************
    cnt_step_a: assert property (CE && !sync_now |=> smp_cnt == $past(smp_cnt) + 3'h1)
        else $error("sample counter did not advance");
    ce_freeze_a: assert property (!CE |=> acc == $past(acc) && smp_cnt == $past(smp_cnt) &&
        OUT_A_I == $past(OUT_A_I) && OUT_B_Q == $past(OUT_B_Q))
        else $error("state moved while clock enable low");
    half_even_a: assert property (CE && coarse_only && cmix == 4'h2 && !smp_cnt[0] |=>
        OUT_A_I == $past(A_I) && OUT_A_Q == $past(A_Q) && OUT_B_I == $past(B_I))
        else $error("fs/2 even sample altered");
    quarter_third_a: assert property (CE && coarse_only && cmix == 4'h4 && smp_cnt[1:0] == 2'h2 |=>
        OUT_A_I == neg_sat($past(A_I)) && OUT_A_Q == neg_sat($past(A_Q)))
        else $error("+fs/4 third sample wrong");
    quarter_nsec_a: assert property (CE && coarse_only && cmix == 4'h1 && smp_cnt[1:0] == 2'h1 |=>
        OUT_A_I == $past(A_Q) && OUT_A_Q == neg_sat($past(A_I)))
        else $error("-fs/4 second sample wrong");
    gain_ignored_a: assert property (CE && coarse_only && cmix == 4'h4 && smp_cnt[1:0] == 2'h0 &&
        gain_sel |=> OUT_A_I == $past(A_I) && OUT_B_Q == $past(B_Q))
        else $error("gain select changed bypassed samples");
    clip_bottom_a: assert property (CE && !full_en && cmix == 4'h8 && gain_sel && smp_cnt == 3'h1 &&
        A_I == `CIM_SAMPLE_MIN && A_Q == `CIM_SAMPLE_MIN |=> OUT_A_Q == `CIM_SAMPLE_MIN)
        else $error("negative overflow wrapped instead of clipping");
endmodule
`default_nettype wire

// File: test/cim_feed.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// Upstream interpolation filter output stage
// ****************************************************
module cim_feed
    import cim_pkg::*;
(
    input wire logic clock, // Sample clock
    input wire logic rst, // Reset, high
    input wire logic [63:0] word, // Next pairs, A then B
    output var cim_sample_t a_i, // Path A in-phase
    output var cim_sample_t a_q, // Path A quadrature
    output var cim_sample_t b_i, // Path B in-phase
    output var cim_sample_t b_q // Path B quadrature
);
    // Full scale is sent with gain one on purpose, so clipping is exercised
    // No downstream trim: the gain zero loss stays visible at the outputs
    always_ff @(posedge clock)
    begin
        if (rst)
            {a_i, a_q, b_i, b_q} <= 64'h0;
        else
            {a_i, a_q, b_i, b_q} <= word;
    end
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import cim_pkg::*;
;
    logic CLOCK = 1'b0;
    logic RST, CE;
    logic [2:0] SYNC_IN;
    logic [63:0] word;
    cim_sample_t A_I, A_Q, B_I, B_Q, OUT_A_I, OUT_A_Q, OUT_B_I, OUT_B_Q;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
    logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic [7:0] m_cfg;
    logic [3:0] m_sel;
    logic [31:0] m_freq, acc;
    logic [15:0] m_ph;
    logic [2:0] n;
    logic track, ev;
    cim_sample_t ea_i, ea_q, eb_i, eb_q;
    logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hA, 4'hC, 4'hE};
    int err_count = 0;
    int check_count = 0;

    always #2 CLOCK = ~CLOCK;

    cim_feed cim_feed_inst (.clock(CLOCK), .rst(RST), .word(word), .a_i(A_I), .a_q(A_Q), .b_i(B_I), .b_q(B_Q));
    cim_mixer cim_mixer_inst (.CLOCK, .RST, .CE, .SYNC_IN, .A_I, .A_Q, .B_I, .B_Q, .OUT_A_I, .OUT_A_Q,
        .OUT_B_I, .OUT_B_Q, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
        .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
        .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);

    // ****************************************************
    // Reference model
    // ****************************************************
    function automatic cim_sample_t sat(input longint v);
        return (v > 32767) ? 16'sh7FFF : (v < -32768) ? 16'sh8000 : cim_sample_t'(v);
    endfunction

    // Table angle in 64ths of a turn, Q15 amplitude
    function automatic int trig(input int a);
        return int'(32767.0 * $cos(6.283185307179586 * a / 64.0));
    endfunction

    function automatic void step(input int i, input int q, output cim_sample_t oi, output cim_sample_t oq);
        int a, c, s, k, sh;
        longint rb;
        cim_sample_t ti, tq;
        ti = cim_sample_t'(i);
        tq = cim_sample_t'(q);
        k = 0;
        sh = m_cfg[1] ? 15 : 16;
        rb = m_cfg[1] ? 16384 : 32768;
        if (m_cfg[0] || m_cfg[7])
        begin
            a = m_cfg[0] ? int'(acc[31:26]) + int'(m_ph[15:10]) : 8 * int'(n);
            c = trig(a);
            s = trig(a - 16);
            ti = sat((longint'(i) * c - longint'(q) * s + rb) >>> sh);
            tq = sat((longint'(i) * s + longint'(q) * c + rb) >>> sh);
        end
        if (!m_cfg[0])
            k = (m_cfg[6] ? int'(n[1:0]) : 0) + (m_cfg[5] ? 2 * int'(n[1:0]) : 0) - (m_cfg[4] ? int'(n[1:0]) : 0);
        case (k & 3)
            1: {oi, oq} = {sat(-longint'(tq)), ti};
            2: {oi, oq} = {sat(-longint'(ti)), sat(-longint'(tq))};
            3: {oi, oq} = {tq, sat(-longint'(ti))};
            default: {oi, oq} = {ti, tq};
        endcase
    endfunction

    always @(posedge CLOCK)
    begin
        ev = track;
        if (RST)
            {acc, n} = 35'h0;
        else if (CE)
        begin
            step(A_I, A_Q, ea_i, ea_q);
            step(B_I, B_Q, eb_i, eb_q);
            acc = acc + m_freq;
            n = n + 3'h1;
            if (|(m_sel[3:1] & SYNC_IN))
                {acc, n} = 35'h0;
        end
    end

    always @(negedge CLOCK)
    begin
        if (ev)
        begin
            check(OUT_A_I, ea_i);
            check(OUT_A_Q, ea_q);
            check(OUT_B_I, eb_i);
            check(OUT_B_Q, eb_q);
        end
    end

    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic timeout();
        err_count++;
        $display("ERROR %0t bus wait ran out", $time);
        results();
    endtask

    // Bus tasks start and end just after a rising edge; handshakes are judged at the falling edge
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        logic ta, tw, bv;
        logic [1:0] br;
        S_AXI_AWADDR <= a;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= 4'hF;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        for (k = 0; k < 64; k++)
        begin
            @(negedge CLOCK);
            ta = S_AXI_AWVALID && S_AXI_AWREADY === 1'b1;
            tw = S_AXI_WVALID && S_AXI_WREADY === 1'b1;
            bv = S_AXI_BVALID === 1'b1;
            br = S_AXI_BRESP;
            @(posedge CLOCK);
            if (ta)
                S_AXI_AWVALID <= 1'b0;
            if (tw)
                S_AXI_WVALID <= 1'b0;
            if (bv)
            begin
                check({30'h0, br}, {30'h0, r});
                break;
            end
        end
        if (k == 64)
            timeout();
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int k;
        logic ta, rv;
        logic [31:0] rd;
        logic [1:0] rr;
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        for (k = 0; k < 64; k++)
        begin
            @(negedge CLOCK);
            ta = S_AXI_ARVALID && S_AXI_ARREADY === 1'b1;
            rv = S_AXI_RVALID === 1'b1;
            {rd, rr} = {S_AXI_RDATA, S_AXI_RRESP};
            @(posedge CLOCK);
            if (ta)
                S_AXI_ARVALID <= 1'b0;
            if (rv)
            begin
                check(rd, d);
                check({30'h0, rr}, {30'h0, r});
                break;
            end
        end
        if (k == 64)
            timeout();
    endtask

    function automatic logic [15:0] rs16();
        int r;
        r = $urandom % 4;
        return (r == 0) ? 16'h7FFF : (r == 1) ? 16'h8000 : 16'($urandom);
    endfunction

    // Program, align the model with one selected sync pulse, then stream with random stalls and syncs
    task automatic run(input logic [7:0] cfg, input logic [31:0] f, input logic [15:0] p, input int cyc);
        m_sel = {3'($urandom % 7 + 1), 1'($urandom)};
        axw(8'h00, {24'h0, cfg}, 2'h0);
        axw(8'h04, {28'h0, m_sel}, 2'h0);
        axw(8'h08, f, 2'h0);
        axw(8'h0C, {16'h0, p}, 2'h0);
        {m_cfg, m_freq, m_ph} = {cfg, f, p};
        SYNC_IN <= m_sel[3:1];
        @(posedge CLOCK);
        SYNC_IN <= 3'h0;
        track <= 1'b1;
        repeat (cyc)
        begin
            word <= {rs16(), rs16(), rs16(), rs16()};
            CE <= ($urandom % 8) != 0;
            SYNC_IN <= ($urandom % 16 == 0) ? 3'($urandom) : 3'h0;
            @(posedge CLOCK);
        end
        track <= 1'b0;
        CE <= 1'b1;
        SYNC_IN <= 3'h0;
        @(posedge CLOCK);
        $display("test cfg %h sel %h done", cfg, m_sel);
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial
    begin
        {RST, CE, SYNC_IN, word, track, m_cfg, m_sel, m_freq, m_ph} = {2'h3, 3'h0, 64'h0, 1'h0, 60'h0};
        {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WSTRB, S_AXI_WVALID, S_AXI_BREADY} = 46'h0;
        {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = 10'h0;
        void'($urandom(32'hCB68));
        repeat (16) @(posedge CLOCK);
        RST <= 1'b0;
        @(negedge CLOCK);
        check(OUT_A_I, 32'h0);
        check(OUT_B_Q, 32'h0);
        @(posedge CLOCK);
        for (int i = 0; i < 5; i++)
            axr(8'(4 * i), 32'h0, 2'h0);
        axr(8'h14, 32'h0, 2'h2);
        axr(8'h02, 32'h0, 2'h2);
        axw(8'h14, 32'hFFFF_FFFF, 2'h2);
        axw(8'h0C, 32'hFFFF_FFFF, 2'h0);
        axr(8'h0C, 32'h0000_FFFF, 2'h0);
        axw(8'h08, 32'hFFFF_FFFF, 2'h0);
        axr(8'h08, 32'hFFFF_FFFF, 2'h0);
        $display("test registers done");
        for (int c = 0; c < 8; c++)
            for (int g = 0; g < 2; g++)
                run({codes[c], 2'h0, 1'(g), 1'h0}, $urandom, 16'($urandom), 40);
        for (int g = 0; g < 2; g++)
            run({4'($urandom), 2'h0, 1'(g), 1'h1}, $urandom, 16'($urandom), 300);
        results();
    end
endmodule
`default_nettype wire
